// ### inc/ocd_regs.vh
// Purpose : constants for the operand and condition decoder
// Assumes : included by bare name from logic/ files
// Notes   : field positions, condition encodings and operand ranges
`ifndef OCD_REGS_VH
`define OCD_REGS_VH

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define OCD_COND_HI        7
`define OCD_COND_LO        4
`define OCD_BIT_HI         3
`define OCD_BIT_LO         1
`define OCD_POL_BIT        0
`define OCD_NIB_HI         7
`define OCD_NIB_LO         4
`define OCD_LOW_HI         3
`define OCD_LOW_LO         0
`define OCD_SIGN_BIT       7
`define OCD_PAIR_LO        1
`define OCD_ODD_BIT        0
`define OCD_REL_EXT        8
`define OCD_IDX_EXT        4

// ---------------------------------------------------------------
// condition encodings
// ---------------------------------------------------------------
`define OCD_TEST_NEVER                4'h0
`define OCD_TEST_SIGNED_LOWER         4'h1
`define OCD_TEST_SIGNED_LOWER_EQUAL   4'h2
`define OCD_TEST_UNSIGNED_LOWER_EQUAL 4'h3
`define OCD_TEST_OVERFLOW             4'h4
`define OCD_TEST_NEGATIVE             4'h5
`define OCD_TEST_ZERO                 4'h6
`define OCD_TEST_CARRY                4'h7
`define OCD_TEST_ALWAYS               4'h8
`define OCD_TEST_SIGNED_HIGHER_EQUAL  4'h9
`define OCD_TEST_SIGNED_HIGHER        4'ha
`define OCD_TEST_UNSIGNED_HIGHER      4'hb
`define OCD_TEST_NO_OVERFLOW          4'hc
`define OCD_TEST_POSITIVE             4'hd
`define OCD_TEST_NONZERO              4'he
`define OCD_TEST_NO_CARRY             4'hf

// ---------------------------------------------------------------
// operand constants
// ---------------------------------------------------------------
`define OCD_ESC_NIBBLE     4'he
`define OCD_OPC_ADD_REG    8'h04
`define OCD_OPC_W          8

`endif

// ### logic/ocd_cond_eval.v
// Purpose : evaluate one condition field against the flags
// Assumes : flags are the committed values of the prior instruction
// Notes   : purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "ocd_regs.vh"

module ocd_cond_eval (
  input  wire [3:0] i_cond,   // condition field
  input  wire       i_c,      // carry
  input  wire       i_z,      // zero
  input  wire       i_s,      // sign
  input  wire       i_v,      // overflow
  output reg        o_take    // test true
);

  // ---------------------------------------------------------------
  // flag test
  // ---------------------------------------------------------------
  wire s_xor_v = i_s ^ i_v;         // signed less-than term
  wire le_term = i_z | s_xor_v;     // signed less-or-equal term

  // upper half is the complement of lower half, 8 against 0 included
  always @* begin
    case (i_cond)
      `OCD_TEST_NEVER:                o_take = 1'b0;
      `OCD_TEST_ALWAYS:               o_take = 1'b1;
      `OCD_TEST_SIGNED_LOWER:         o_take = s_xor_v;
      `OCD_TEST_SIGNED_LOWER_EQUAL:   o_take = le_term;
      `OCD_TEST_SIGNED_HIGHER_EQUAL:  o_take = ~s_xor_v;
      `OCD_TEST_SIGNED_HIGHER:        o_take = ~le_term;
      `OCD_TEST_UNSIGNED_LOWER_EQUAL: o_take = i_c | i_z;
      `OCD_TEST_UNSIGNED_HIGHER:      o_take = ~i_c & ~i_z;
      `OCD_TEST_OVERFLOW:             o_take = i_v;
      `OCD_TEST_NEGATIVE:             o_take = i_s;
      `OCD_TEST_ZERO:                 o_take = i_z;
      `OCD_TEST_CARRY:                o_take = i_c;
      `OCD_TEST_NO_OVERFLOW:          o_take = ~i_v;
      `OCD_TEST_POSITIVE:             o_take = ~i_s;
      `OCD_TEST_NONZERO:              o_take = ~i_z;
      `OCD_TEST_NO_CARRY:             o_take = ~i_c;
      default:                        o_take = 1'b0;        // unreachable, safe value
    endcase
  end

endmodule // ocd_cond_eval
`default_nettype wire

// ### logic/ocd_operand_decoder.v
// Purpose : operand field and conditional jump decoder
// Assumes : opcode and operand bytes presented with a load strobe
// Notes   : results are registered one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
`include "ocd_regs.vh"

module ocd_operand_decoder (
  input  wire        I_CLK,          // core clock
  input  wire        I_RST,          // async reset, high
  input  wire        i_load,         // operands valid this cycle
  input  wire [7:0]  i_opcode,       // opcode byte
  input  wire [7:0]  i_op1,          // first operand byte
  input  wire [7:0]  i_op2,          // second operand byte
  input  wire [7:0]  i_rp,           // working bank base
  input  wire [15:0] i_next_pc,      // address after this instruction
  input  wire [11:0] i_index_base,   // base for indexed form
  input  wire        i_flag_c,       // committed carry
  input  wire        i_flag_z,       // committed zero
  input  wire        i_flag_s,       // committed sign
  input  wire        i_flag_v,       // committed overflow
  output reg         o_valid,        // results updated, pulse
  output reg  [3:0]  o_condition_field, // condition selector
  output reg         o_jump_taken,   // conditional jump taken
  output reg  [15:0] o_jump_target,  // relative jump target
  output reg  [15:0] o_direct_addr,  // direct address operand
  output reg  [11:0] o_src_addr,     // resolved source register
  output reg  [11:0] o_dst_addr,     // resolved destination register
  output reg         o_src_esc,      // source in working form
  output reg         o_dst_esc,      // destination in working form
  output reg  [11:0] o_extended_register_operand, // 12-bit register
  output reg  [11:0] o_indexed_addr, // base plus signed index
  output reg  [7:0]  o_register_pair_operand, // even pair register
  output reg  [3:0]  o_working_pair_operand,  // even working pair
  output reg         o_pair_odd,     // odd pair number seen
  output reg  [2:0]  o_bit_sel,      // bit position
  output reg         o_polarity,     // polarity bit
  output reg  [7:0]  o_immediate_operand // immediate or vector byte
);

  // ---------------------------------------------------------------
  // operand ordering
  // ---------------------------------------------------------------
  // register-to-register add carries source first; other opcodes
  // keep the destination first here, the core may override order
  wire        is_add_reg = (i_opcode == `OCD_OPC_ADD_REG);
  wire [7:0]  src_byte   = is_add_reg ? i_op1 : i_op2;
  wire [7:0]  dst_byte   = is_add_reg ? i_op2 : i_op1;

  // ---------------------------------------------------------------
  // register fields
  // ---------------------------------------------------------------
  wire        src_esc;   // source escaped
  wire [11:0] src_addr;  // source resolved
  wire        dst_esc;   // destination escaped
  wire [11:0] dst_addr;  // destination resolved

  ocd_reg_field u_src (
    .i_byte (src_byte),
    .i_rp   (i_rp),
    .o_esc  (src_esc),
    .o_addr (src_addr)
  );

  ocd_reg_field u_dst (
    .i_byte (dst_byte),
    .i_rp   (i_rp),
    .o_esc  (dst_esc),
    .o_addr (dst_addr)
  );

  // ---------------------------------------------------------------
  // condition evaluation
  // ---------------------------------------------------------------
  wire [3:0] cond = i_opcode[`OCD_COND_HI:`OCD_COND_LO];
  wire       take;  // flag test result

  // flags come straight from the committed flag register
  ocd_cond_eval u_cond (
    .i_cond (cond),
    .i_c    (i_flag_c),
    .i_z    (i_flag_z),
    .i_s    (i_flag_s),
    .i_v    (i_flag_v),
    .o_take (take)
  );

  // ---------------------------------------------------------------
  // address arithmetic
  // ---------------------------------------------------------------
  // sign extension keeps offsets within +127..-128
  wire [15:0] rel_ext   = {{`OCD_REL_EXT{i_op1[`OCD_SIGN_BIT]}}, i_op1};
  wire [15:0] next_tgt  = i_next_pc + rel_ext;
  wire [11:0] idx_ext   = {{`OCD_IDX_EXT{i_op2[`OCD_SIGN_BIT]}}, i_op2};
  wire [11:0] next_idx  = i_index_base + idx_ext;
  // wraps within the 12-bit register space, no carry out

  // ---------------------------------------------------------------
  // registered results
  // ---------------------------------------------------------------
  // outputs other than o_valid hold between strobes so the core may sample late
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      o_valid                     <= 1'b0;
      o_condition_field           <= 4'h0;
      o_jump_taken                <= 1'b0;
      o_jump_target               <= 16'h0000;
      o_direct_addr               <= 16'h0000;
      o_src_addr                  <= 12'h000;
      o_dst_addr                  <= 12'h000;
      o_src_esc                   <= 1'b0;
      o_dst_esc                   <= 1'b0;
      o_extended_register_operand <= 12'h000;
      o_indexed_addr              <= 12'h000;
      o_register_pair_operand     <= 8'h00;
      o_working_pair_operand      <= 4'h0;
      o_pair_odd                  <= 1'b0;
      o_bit_sel                   <= 3'h0;
      o_polarity                  <= 1'b0;
      o_immediate_operand         <= 8'h00;
    end else begin
      o_valid <= i_load;                                       // one-cycle pulse
      if (i_load) begin
        o_condition_field <= cond;
        o_jump_taken      <= take;
        // target always computed; core uses it only if taken
        o_jump_target     <= next_tgt;
        o_direct_addr     <= {i_op1, i_op2};
        o_src_addr        <= src_addr;
        o_dst_addr        <= dst_addr;
        o_src_esc         <= src_esc;
        o_dst_esc         <= dst_esc;
        o_extended_register_operand <= {i_op1[`OCD_LOW_HI:`OCD_LOW_LO], i_op2};
        o_indexed_addr    <= next_idx;
        // low bit forced clear: pairs are even only
        o_register_pair_operand <= {dst_byte[`OCD_NIB_HI:`OCD_PAIR_LO], 1'b0};
        o_working_pair_operand  <= {dst_byte[`OCD_LOW_HI:`OCD_PAIR_LO], 1'b0};
        o_pair_odd        <= dst_byte[`OCD_ODD_BIT];
        o_bit_sel         <= i_op1[`OCD_BIT_HI:`OCD_BIT_LO];
        o_polarity        <= i_op1[`OCD_POL_BIT];
        o_immediate_operand <= i_op2;
      end
    end
  end

endmodule // ocd_operand_decoder
`default_nettype wire

// ### logic/ocd_reg_field.v
// Purpose : decode one 8-bit register address operand
// Assumes : working register pointer supplied by the core
// Notes   : escaped form maps nibble e onto the working bank
`timescale 1ns/1ps
`default_nettype none
`include "ocd_regs.vh"

module ocd_reg_field (
  input  wire [7:0]  i_byte,   // operand byte
  input  wire [7:0]  i_rp,     // working bank base, upper bits
  output wire        o_esc,    // escaped working form
  output wire [11:0] o_addr    // resolved 12-bit register
);

  // ---------------------------------------------------------------
  // escape detect
  // ---------------------------------------------------------------
  assign o_esc  = (i_byte[`OCD_NIB_HI:`OCD_NIB_LO] == `OCD_ESC_NIBBLE);
  // escaped: working bank plus low nibble; else plain 0-255
  assign o_addr = o_esc ? {i_rp, i_byte[`OCD_LOW_HI:`OCD_LOW_LO]} : {4'h0, i_byte};

endmodule // ocd_reg_field
`default_nettype wire

// ### verif/ocd_operand_decoder_monitor.sv
// Purpose: port checks for the operand and condition decoder
// Assumes: one clock, asynchronous active-high reset
// Notes  : every result lands exactly one edge after its load
`timescale 1ns/1ps
`default_nettype none
module ocd_monitor (
  input wire logic        I_CLK,             // core clock
  input wire logic        I_RST,             // async reset
  input wire logic        i_load,            // load strobe
  input wire logic [7:0]  i_opcode,          // opcode byte
  input wire logic [7:0]  i_op1,             // first operand
  input wire logic [7:0]  i_op2,             // second operand
  input wire logic [15:0] i_next_pc,         // next address
  input wire logic        i_flag_c,          // carry
  input wire logic        i_flag_z,          // zero
  input wire logic        i_flag_s,          // sign
  input wire logic        i_flag_v,          // overflow
  input wire logic        o_valid,           // result strobe
  input wire logic [3:0]  o_condition_field, // selector
  input wire logic        o_jump_taken,      // decision
  input wire logic [15:0] o_jump_target,     // jump target
  input wire logic [15:0] o_direct_addr      // direct address
);
  // ---------------------------------------------------------------
  // reference flag tests, indexed by the low selector bits
  // ---------------------------------------------------------------
  logic [7:0]  test_row;  // one entry per base test
  logic        want_take; // top selector bit inverts the test
  logic [15:0] want_tgt;  // offset counts from the next address
  assign test_row = {i_flag_c, i_flag_z, i_flag_s, i_flag_v, i_flag_c | i_flag_z,
                     i_flag_z | (i_flag_s ^ i_flag_v), i_flag_s ^ i_flag_v, 1'b0};
  assign want_take = test_row[i_opcode[6:4]] ^ i_opcode[7];
  assign want_tgt = i_next_pc + {{8{i_op1[7]}}, i_op1};

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  valid_pulse_a: assert property (i_load |=> o_valid)
    else $error("result strobe missing after load");
  idle_quiet_a: assert property (!i_load |=> !o_valid && $stable(o_jump_taken) && $stable(o_jump_target))
    else $error("results moved without a load");
  cond_field_a: assert property (i_load |=> o_condition_field == $past(i_opcode[7:4]))
    else $error("selector not taken from opcode upper nibble");
  never_jump_a: assert property (i_load && i_opcode[7:4] == 4'h0 |=> !o_jump_taken)
    else $error("never-code took the jump");
  always_jump_a: assert property (i_load && i_opcode[7:4] == 4'h8 |=> o_jump_taken)
    else $error("always-code skipped the jump");
  flag_test_a: assert property (i_load |=> o_jump_taken == $past(want_take))
    else $error("jump decision disagrees with flags");
  rel_target_a: assert property (i_load |=> o_jump_target == $past(want_tgt))
    else $error("relative target wrong");
  direct_addr_a: assert property (i_load |=> o_direct_addr == {$past(i_op1), $past(i_op2)})
    else $error("direct address wrong");
endmodule // ocd_monitor

bind ocd_operand_decoder ocd_monitor u_mon (.*);
`default_nettype wire

// ### verif/ocd_operand_decoder_tb.sv
// Purpose: self-checking bench for the operand and condition decoder
// Assumes: results one edge after each load, data held between loads
// Notes  : all 16 selectors against all 16 flag sets, then random traffic
`timescale 1ns/1ps
`default_nettype none
module ocd_operand_decoder_tb;
  typedef struct packed {
    logic [3:0] cf; logic tk; logic [15:0] tg, da; logic [11:0] sa, dd; logic se, de;
    logic [11:0] ex, ix; logic [7:0] pr; logic [3:0] wp; logic od; logic [2:0] bs; logic pl; logic [7:0] im;
  } ocd_exp_t;
  logic        I_CLK, I_RST, i_load, i_flag_c, i_flag_z, i_flag_s, i_flag_v; // stimulus
  logic [7:0]  i_opcode, i_op1, i_op2, i_rp;                                 // bytes
  logic [15:0] i_next_pc;                                                     // next address
  logic [11:0] i_index_base;                                                  // index base
  logic        o_valid, o_jump_taken, o_src_esc, o_dst_esc, o_pair_odd, o_polarity;
  logic [3:0]  o_condition_field, o_working_pair_operand;
  logic [15:0] o_jump_target, o_direct_addr;
  logic [11:0] o_src_addr, o_dst_addr, o_extended_register_operand, o_indexed_addr;
  logic [7:0]  o_register_pair_operand, o_immediate_operand;
  logic [2:0]  o_bit_sel;
  ocd_exp_t    q[$];        // expectations in load order
  ocd_exp_t    x;           // oldest expectation
  logic [63:0] r;           // random word
  int          error_cnt = 0, compares = 0, cycles = 0;

  ocd_operand_decoder dut (.*);

  // ---------------------------------------------------------------
  // clock, timeout and reporting
  // ---------------------------------------------------------------
  always #5 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    cycles++;
    if (cycles == 1500) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // expected results, worked out from the current inputs
  // ---------------------------------------------------------------
  function automatic ocd_exp_t expect_f();
    ocd_exp_t e;
    logic [7:0] sb, db, row;
    sb = i_opcode == 8'h04 ? i_op1 : i_op2; // add form: source byte first
    db = i_opcode == 8'h04 ? i_op2 : i_op1;
    row = {i_flag_c, i_flag_z, i_flag_s, i_flag_v, i_flag_c | i_flag_z,
           i_flag_z | (i_flag_s ^ i_flag_v), i_flag_s ^ i_flag_v, 1'b0};
    e = '{cf: i_opcode[7:4], tk: row[i_opcode[6:4]] ^ i_opcode[7], tg: i_next_pc + {{8{i_op1[7]}}, i_op1},
          da: {i_op1, i_op2}, se: sb[7:4] == 4'he, de: db[7:4] == 4'he,
          sa: sb[7:4] == 4'he ? {i_rp, sb[3:0]} : {4'h0, sb}, dd: db[7:4] == 4'he ? {i_rp, db[3:0]} : {4'h0, db},
          ex: {i_op1[3:0], i_op2}, ix: i_index_base + {{4{i_op2[7]}}, i_op2}, pr: {db[7:1], 1'b0},
          wp: {db[3:1], 1'b0}, od: db[0], bs: i_op1[3:1], pl: i_op1[0], im: i_op2};
    return e;
  endfunction

  // ---------------------------------------------------------------
  // result watcher, samples on the falling edge once outputs settle
  // ---------------------------------------------------------------
  always @(negedge I_CLK) begin
    if (I_RST) begin
      chk(16'({o_valid, o_jump_taken, o_condition_field}), 16'h0);
    end else if (o_valid === 1'b1) begin
      chk(16'(q.size() != 0), 16'h1);
      if (q.size() != 0) x = q.pop_front();
      chk(16'(o_condition_field), 16'(x.cf));
      chk(16'(o_jump_taken), 16'(x.tk));
      chk(o_jump_target, x.tg);
      chk(o_direct_addr, x.da);
      chk(16'(o_src_addr), 16'(x.sa));
      chk(16'(o_dst_addr), 16'(x.dd));
      chk(16'({o_src_esc, o_dst_esc}), 16'({x.se, x.de}));
      chk(16'(o_extended_register_operand), 16'(x.ex));
      chk(16'(o_indexed_addr), 16'(x.ix));
      chk(16'({o_register_pair_operand, o_working_pair_operand, o_pair_odd}), 16'({x.pr, x.wp, x.od}));
      chk(16'({o_bit_sel, o_polarity}), 16'({x.bs, x.pl}));
      chk(16'(o_immediate_operand), 16'(x.im));
    end
  end

  // ---------------------------------------------------------------
  // stimulus: exhaustive selector sweep, then gaps, escapes, reset
  // ---------------------------------------------------------------
  initial begin
    I_CLK = 1'b0;
    I_RST = 1'b1;
    {i_load, i_opcode, i_op1, i_op2, i_rp, i_next_pc, i_index_base} = '0;
    {i_flag_c, i_flag_z, i_flag_s, i_flag_v} = 4'h0;
    void'($urandom(57041));
    repeat (9) @(posedge I_CLK);
    for (int n = 0; n < 700; n++) begin
      @(posedge I_CLK);
      #1;
      r = {$urandom, $urandom};
      I_RST = n == 401;                                  // second reset in mid-run
      {i_next_pc, i_index_base, i_rp, i_op1, i_op2} = r[51:0];
      if (r[52]) i_op1[7:4] = 4'he;                      // escaped working form
      if (r[53]) i_op2[7:4] = 4'he;
      if (r[54] & r[55]) i_op1 = r[56] ? 8'h7f : 8'h80; // offset extremes
      i_opcode = (n > 255 && r[57]) ? 8'h04 : {n[3:0], r[63:60]};
      {i_flag_c, i_flag_z, i_flag_s, i_flag_v} = n < 256 ? n[7:4] : r[61:58];
      // load gaps drawn apart from the flags so every flag set reaches a load
      i_load = n < 256 || (n != 400 && n != 401 && $urandom_range(3) != 0);
      if (i_load) q.push_back(expect_f());
    end
    @(posedge I_CLK);
    #1;
    i_load = 1'b0;
    repeat (3) @(posedge I_CLK);
    chk(16'(q.size()), 16'h0);
    end_of_test();
  end
endmodule // ocd_operand_decoder_tb
`default_nettype wire
